// File: pkg/fcc_pkg.sv
package fcc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADR_W  = 18;
    localparam int DAT_W  = 32;
    localparam int REG_W  = 16;
    localparam int IDX_W  = 16;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_SUBSYS_STATUS = 16'h0011;
    localparam logic [15:0] IDX_SUBSYS_CLEAR  = 16'h0012;
    localparam logic [15:0] IDX_SUBSYS_MASK   = 16'h0021;
    localparam logic [15:0] IDX_CHK_ENABLE    = 16'h8001;
    localparam logic [15:0] IDX_IRQ_ENABLE    = 16'h8004;
    localparam logic [15:0] IDX_SOURCE_SELECT = 16'h8005;
    localparam logic [15:0] IDX_RX_ERR_COUNT  = 16'h8008;
    localparam logic [15:0] IDX_FRAME_HIGH    = 16'h8009;
    localparam logic [15:0] IDX_FRAME_LOW     = 16'h800a;
    localparam logic [15:0] IDX_LEN_ERR       = 16'h800b;
    localparam logic [15:0] IDX_ALGN_ERR      = 16'h800c;
    localparam logic [15:0] IDX_SYMB_ERR      = 16'h800d;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_BIT      = 0;
    localparam int CHK_IRQ_BIT   = 14;
    localparam int CHK_IRQ_LANE  = 1;
    localparam logic        CHK_ENABLE_RST = 1'b1;
    localparam logic        IRQ_ENABLE_RST = 1'b1;
    localparam logic        SOURCE_SEL_RST = 1'b0;
    localparam logic [15:0] MASK_RST       = 16'h2402;
    localparam logic        SRC_PHY_RX     = 1'b0;
    localparam logic        SRC_MAC_TX     = 1'b1;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    localparam int FRAME_CNT_W = 32;
    localparam int ERR_CNT_W   = 16;
    localparam int N_CLASS     = 3;
    localparam int CLS_LEN     = 0;
    localparam int CLS_ALGN    = 1;
    localparam int CLS_SYMB    = 2;

    // one frame stream, same clock as the checker
    typedef struct packed {
        logic dv;
        logic er;
        logic eof;
        logic len_err;
        logic algn_err;
        logic crc_err;
    } fcc_stream_t;

endpackage

// File: src/fcc_stat_counter.sv
`timescale 1ns/10ps
module fcc_stat_counter #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         inc_i,
    input  wire logic         clear_i,
    input  wire logic         capture_i,
    output logic [W-1:0]      live_o,
    output logic [W-1:0]      held_o
);

    // ------------------------------------------------------------
    // live count, saturating
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live_o <= '0;
        end else if (clear_i) begin
            // an event on the clearing edge still counts
            live_o <= inc_i ? W'(1) : '0;
        end else if (inc_i && (live_o != '1)) begin
            live_o <= live_o + W'(1);
        end
    end

    // ------------------------------------------------------------
    // held copy, taken before this edge's update
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held_o <= '0;
        end else if (capture_i) begin
            held_o <= live_o;
        end
    end

endmodule

// File: src/fcc_frame_checker.sv
`timescale 1ns/10ps
module fcc_frame_checker (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [fcc_pkg::ADR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [fcc_pkg::DAT_W-1:0]     wb_dat_i,
    output logic      [fcc_pkg::DAT_W-1:0]     wb_dat_o,
    output logic                               wb_ack_o,
    input  wire fcc_pkg::fcc_stream_t          phy_rx_i,
    input  wire fcc_pkg::fcc_stream_t          mac_tx_i,
    output logic                               irq_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                              chk_enable;
    logic                              irq_enable;
    logic                              source_select;
    logic [fcc_pkg::REG_W-1:0]         subsystem_interrupt_mask;
    logic                              checker_generator_irq_latched;
    logic                              sym_seen;
    fcc_pkg::fcc_stream_t              stream;
    logic                              frame_done;
    logic [fcc_pkg::N_CLASS-1:0]       class_err;
    logic                              any_err;
    logic                              irq_event;
    logic                              req;
    logic                              rd_req;
    logic                              wr_req;
    logic [fcc_pkg::IDX_W-1:0]         idx;
    logic                              rd_err_count;
    logic                              rd_status;
    logic                              wr_clear;
    logic [fcc_pkg::DAT_W-1:0]         next_rdata;
    logic [fcc_pkg::FRAME_CNT_W-1:0]   frame_held;
    logic [fcc_pkg::ERR_CNT_W-1:0]     rx_err_live;
    logic [fcc_pkg::ERR_CNT_W-1:0]     class_held [fcc_pkg::N_CLASS];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(
        input logic [fcc_pkg::IDX_W-1:0] a,
        input logic [fcc_pkg::IDX_W-1:0] b
    );
        hit = (a == b);
    endfunction

    function automatic logic [fcc_pkg::REG_W-1:0] merge_lanes(
        input logic [fcc_pkg::REG_W-1:0] old,
        input logic [fcc_pkg::DAT_W-1:0] dat,
        input logic [3:0]                sel
    );
        merge_lanes = old;
        if (sel[0]) begin
            merge_lanes[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            merge_lanes[15:8] = dat[15:8];
        end
    endfunction

    // ------------------------------------------------------------
    // wishbone decode
    // ------------------------------------------------------------
    // one wait state: the ack edge is also the edge that takes effect
    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_req = req & ~wb_we_i;
    assign wr_req = req & wb_we_i;
    assign idx    = wb_adr_i[fcc_pkg::ADR_W-1:2];

    assign rd_err_count = rd_req & hit(idx, fcc_pkg::IDX_RX_ERR_COUNT);
    assign rd_status    = rd_req & hit(idx, fcc_pkg::IDX_SUBSYS_STATUS);
    assign wr_clear     = wr_req & hit(idx, fcc_pkg::IDX_SUBSYS_CLEAR)
                        & wb_sel_i[fcc_pkg::CHK_IRQ_LANE]
                        & wb_dat_i[fcc_pkg::CHK_IRQ_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chk_enable <= fcc_pkg::CHK_ENABLE_RST;
        end else if (wr_req && wb_sel_i[0] && hit(idx, fcc_pkg::IDX_CHK_ENABLE)) begin
            chk_enable <= wb_dat_i[fcc_pkg::CTRL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_enable <= fcc_pkg::IRQ_ENABLE_RST;
        end else if (wr_req && wb_sel_i[0] && hit(idx, fcc_pkg::IDX_IRQ_ENABLE)) begin
            irq_enable <= wb_dat_i[fcc_pkg::CTRL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            source_select <= fcc_pkg::SOURCE_SEL_RST;
        end else if (wr_req && wb_sel_i[0] && hit(idx, fcc_pkg::IDX_SOURCE_SELECT)) begin
            source_select <= wb_dat_i[fcc_pkg::CTRL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            subsystem_interrupt_mask <= fcc_pkg::MASK_RST;
        end else if (wr_req && hit(idx, fcc_pkg::IDX_SUBSYS_MASK)) begin
            subsystem_interrupt_mask <= merge_lanes(subsystem_interrupt_mask,
                                                    wb_dat_i, wb_sel_i);
        end
    end

    // ------------------------------------------------------------
    // stream selection and frame classification
    // ------------------------------------------------------------
    assign stream = (source_select == fcc_pkg::SRC_MAC_TX) ? mac_tx_i : phy_rx_i;

    // symbol error may appear on any nibble, so remember it until frame end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sym_seen <= 1'b0;
        end else if (stream.eof || !chk_enable) begin
            sym_seen <= 1'b0;
        end else if (stream.dv && stream.er) begin
            sym_seen <= 1'b1;
        end
    end

    assign frame_done = chk_enable & stream.eof;

    assign class_err[fcc_pkg::CLS_LEN]  = stream.len_err;
    assign class_err[fcc_pkg::CLS_ALGN] = stream.algn_err;
    assign class_err[fcc_pkg::CLS_SYMB] = sym_seen | (stream.dv & stream.er);

    assign any_err   = (|class_err) | stream.crc_err;
    assign irq_event = frame_done & any_err & irq_enable;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    fcc_stat_counter #(
        .W (fcc_pkg::FRAME_CNT_W)
    ) u_frame_cnt (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .inc_i     (frame_done),
        .clear_i   (1'b0),
        .capture_i (rd_err_count),
        .live_o    (),
        .held_o    (frame_held)
    );

    fcc_stat_counter #(
        .W (fcc_pkg::ERR_CNT_W)
    ) u_receive_error_count (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .inc_i     (frame_done & any_err),
        .clear_i   (rd_err_count),
        .capture_i (1'b0),
        .live_o    (rx_err_live),
        .held_o    ()
    );

    generate
        for (genvar c = 0; c < fcc_pkg::N_CLASS; c++) begin : g_class
            fcc_stat_counter #(
                .W (fcc_pkg::ERR_CNT_W)
            ) u_cls_cnt (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .inc_i     (frame_done & class_err[c]),
                .clear_i   (1'b0),
                .capture_i (rd_err_count),
                .live_o    (),
                .held_o    (class_held[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    // a new event on the clearing edge keeps the bit set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            checker_generator_irq_latched <= 1'b0;
        end else if (irq_event) begin
            checker_generator_irq_latched <= 1'b1;
        end else if (rd_status || wr_clear) begin
            checker_generator_irq_latched <= 1'b0;
        end
    end

    assign irq_o = checker_generator_irq_latched
                 & subsystem_interrupt_mask[fcc_pkg::CHK_IRQ_BIT];

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        unique case (idx)
            fcc_pkg::IDX_SUBSYS_STATUS: begin
                next_rdata[fcc_pkg::CHK_IRQ_BIT] = checker_generator_irq_latched;
            end
            fcc_pkg::IDX_SUBSYS_MASK: begin
                next_rdata[fcc_pkg::REG_W-1:0] = subsystem_interrupt_mask;
            end
            fcc_pkg::IDX_CHK_ENABLE: begin
                next_rdata[fcc_pkg::CTRL_BIT] = chk_enable;
            end
            fcc_pkg::IDX_IRQ_ENABLE: begin
                next_rdata[fcc_pkg::CTRL_BIT] = irq_enable;
            end
            fcc_pkg::IDX_SOURCE_SELECT: begin
                next_rdata[fcc_pkg::CTRL_BIT] = source_select;
            end
            fcc_pkg::IDX_RX_ERR_COUNT: begin
                next_rdata[fcc_pkg::REG_W-1:0] = rx_err_live;
            end
            fcc_pkg::IDX_FRAME_HIGH: begin
                next_rdata[fcc_pkg::REG_W-1:0] = frame_held[31:16];
            end
            fcc_pkg::IDX_FRAME_LOW: begin
                next_rdata[fcc_pkg::REG_W-1:0] = frame_held[15:0];
            end
            fcc_pkg::IDX_LEN_ERR: begin
                next_rdata[fcc_pkg::REG_W-1:0] = class_held[fcc_pkg::CLS_LEN];
            end
            fcc_pkg::IDX_ALGN_ERR: begin
                next_rdata[fcc_pkg::REG_W-1:0] = class_held[fcc_pkg::CLS_ALGN];
            end
            fcc_pkg::IDX_SYMB_ERR: begin
                next_rdata[fcc_pkg::REG_W-1:0] = class_held[fcc_pkg::CLS_SYMB];
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (rd_req) begin
            wb_dat_o <= next_rdata;
        end
    end

endmodule

// File: verification/fcc_frame_checker_props.sv
`timescale 1ns/10ps
module fcc_frame_checker_props (
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [fcc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]                wb_sel_i,
    input wire logic [fcc_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [fcc_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire fcc_pkg::fcc_stream_t      phy_rx_i,
    input wire fcc_pkg::fcc_stream_t      mac_tx_i,
    input wire logic                      irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic [15:0] idx = wb_adr_i[17:2];
    wire logic        take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic        rd_take = take && !wb_we_i;
    wire logic        eof_any = phy_rx_i.eof || mac_tx_i.eof;
    logic             rx_clean;
    // any frame end may bump the error count, so only a quiet gap proves the clear
    always_ff @(posedge clk_i) begin
        if (rst_i || eof_any) begin
            rx_clean <= 1'b0;
        end else if (rd_take && idx == fcc_pkg::IDX_RX_ERR_COUNT) begin
            rx_clean <= 1'b1;
        end
    end
    ack_after_take_a: assert property (take |=> wb_ack_o)
        else $error("request not acked one cycle later");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    unmapped_zero_a: assert property (rd_take && idx inside {16'h8002, 16'h8003, 16'h8006,
        16'h8007} |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    irq_cause_a: assert property ($rose(irq_o) |-> $past(eof_any || (take && wb_we_i)))
        else $error("interrupt rose without frame end or write");
    irq_hold_a: assert property (irq_o && !take |=> irq_o)
        else $error("interrupt dropped without bus access");
    status_read_a: assert property (irq_o && rd_take && idx == fcc_pkg::IDX_SUBSYS_STATUS
        |=> wb_dat_o[14])
        else $error("status read misses checker bit");
    status_clear_a: assert property (rd_take && idx == fcc_pkg::IDX_SUBSYS_STATUS && !eof_any
        |=> !irq_o)
        else $error("status read did not clear interrupt");
    rxerr_clear_a: assert property (rd_take && idx == fcc_pkg::IDX_RX_ERR_COUNT && rx_clean
        |=> wb_dat_o[15:0] == 16'h0000)
        else $error("error count not cleared by read");
    cover property ($rose(irq_o));
    cover property (rd_take && idx == fcc_pkg::IDX_RX_ERR_COUNT);
    cover property (take && wb_we_i && idx == fcc_pkg::IDX_SUBSYS_CLEAR);
endmodule

bind fcc_frame_checker fcc_frame_checker_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phy_rx_i(phy_rx_i), .mac_tx_i(mac_tx_i),
    .irq_o(irq_o)
);

// File: verification/fcc_stream_model.sv
`timescale 1ns/10ps
module fcc_stream_model (
    input  wire logic            clk_i,
    output fcc_pkg::fcc_stream_t frm_o
);
    // idle lines carry junk: only eof qualifies status bits, only dv qualifies er
    localparam fcc_pkg::fcc_stream_t IDLE = 6'h17;
    initial begin
        frm_o = IDLE;
    end
    // e = {symbol on last beat, symbol, length, alignment, crc}
    task automatic send(input logic [4:0] e);
        @(posedge clk_i);
        frm_o <= {1'b1, e[3], 1'b0, 3'h7};
        @(posedge clk_i);
        frm_o <= {1'b1, e[4], 1'b1, e[2:0]};
        @(posedge clk_i);
        frm_o <= IDLE;
    endtask
endmodule

// File: verification/fcc_frame_checker_tb_top.sv
`timescale 1ns/10ps
module fcc_frame_checker_tb_top;
    logic                      clk_i = 1'b0;
    logic                      rst_i = 1'b1;
    logic                      wb_cyc_i = 1'b0;
    logic                      wb_stb_i = 1'b0;
    logic                      wb_we_i = 1'b0;
    logic [fcc_pkg::ADR_W-1:0] wb_adr_i = 18'h00000;
    logic [3:0]                wb_sel_i = 4'h0;
    logic [fcc_pkg::DAT_W-1:0] wb_dat_i = 32'h0;
    logic [fcc_pkg::DAT_W-1:0] wb_dat_o;
    logic                      wb_ack_o;
    logic                      irq_o;
    fcc_pkg::fcc_stream_t      phy_rx_i;
    fcc_pkg::fcc_stream_t      mac_tx_i;
    logic [31:0]               rd;
    int                        err_total = 0;
    int                        checks = 0;

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    fcc_frame_checker dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phy_rx_i(phy_rx_i), .mac_tx_i(mac_tx_i),
        .irq_o(irq_o)
    );
    fcc_stream_model phy (.clk_i(clk_i), .frm_o(phy_rx_i));
    fcc_stream_model mac (.clk_i(clk_i), .frm_o(mac_tx_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic xfer_sel(input logic we, input logic [15:0] idx, input logic [31:0] d,
                            input logic [3:0] sel, input logic [1:0] lo);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, lo};
        wb_dat_i <= d;
        wb_sel_i <= sel;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            tally_and_finish();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic xfer(input logic we, input logic [15:0] idx, input logic [31:0] d);
        xfer_sel(we, idx, d, 4'h3, 2'h0);
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk($sformatf("reg %h", idx), rd, exp);
    endtask

    task automatic irqchk(input logic e);
        chk("irq_o", {31'h0, irq_o}, {31'h0, e});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [15:0] ri [12] = '{fcc_pkg::IDX_CHK_ENABLE, fcc_pkg::IDX_IRQ_ENABLE,
            fcc_pkg::IDX_SOURCE_SELECT, fcc_pkg::IDX_SUBSYS_MASK, fcc_pkg::IDX_SUBSYS_STATUS,
            fcc_pkg::IDX_RX_ERR_COUNT, fcc_pkg::IDX_FRAME_HIGH, fcc_pkg::IDX_FRAME_LOW,
            fcc_pkg::IDX_LEN_ERR, fcc_pkg::IDX_ALGN_ERR, fcc_pkg::IDX_SYMB_ERR, 16'h8002};
        logic [31:0] rv [12] = '{32'h1, 32'h1, 32'h0, 32'h2402, 32'h0, 32'h0, 32'h0, 32'h0,
            32'h0, 32'h0, 32'h0, 32'h0};
        // read-only and unmapped places must ignore writes
        xfer(1'b1, fcc_pkg::IDX_FRAME_LOW, 32'hffff);
        xfer(1'b1, 16'h8002, 32'hffff);
        for (int i = 0; i < 12; i++) begin
            rdchk(ri[i], rv[i]);
        end
        irqchk(1'b0);
    endtask

    task automatic t_count();
        phy.send(4'h0);
        phy.send(4'h4);
        phy.send(4'h2);
        phy.send(4'h8);
        phy.send(4'h1);
        mac.send(4'h4);
        @(posedge clk_i);
        irqchk(1'b0);
        rdchk(fcc_pkg::IDX_RX_ERR_COUNT, 32'h4);
        rdchk(fcc_pkg::IDX_RX_ERR_COUNT, 32'h0);
        rdchk(fcc_pkg::IDX_FRAME_HIGH, 32'h0);
        rdchk(fcc_pkg::IDX_FRAME_LOW, 32'h5);
        rdchk(fcc_pkg::IDX_LEN_ERR, 32'h1);
        rdchk(fcc_pkg::IDX_ALGN_ERR, 32'h1);
        rdchk(fcc_pkg::IDX_SYMB_ERR, 32'h1);
        rdchk(fcc_pkg::IDX_SUBSYS_STATUS, 32'h4000);
        rdchk(fcc_pkg::IDX_SUBSYS_STATUS, 32'h0);
    endtask

    task automatic t_irq();
        xfer(1'b1, fcc_pkg::IDX_SUBSYS_MASK, 32'h6402);
        xfer(1'b1, fcc_pkg::IDX_SOURCE_SELECT, 32'h1);
        rdchk(fcc_pkg::IDX_SOURCE_SELECT, 32'h1);
        phy.send(4'h4);
        mac.send(4'h4);
        @(posedge clk_i);
        irqchk(1'b1);
        rdchk(fcc_pkg::IDX_SUBSYS_STATUS, 32'h4000);
        irqchk(1'b0);
        mac.send(4'h1);
        @(posedge clk_i);
        irqchk(1'b1);
        xfer(1'b1, fcc_pkg::IDX_SUBSYS_CLEAR, 32'h4000);
        irqchk(1'b0);
        xfer(1'b1, fcc_pkg::IDX_IRQ_ENABLE, 32'h0);
        mac.send(4'h2);
        @(posedge clk_i);
        irqchk(1'b0);
        rdchk(fcc_pkg::IDX_SUBSYS_STATUS, 32'h0);
        // frames while the checker is off must leave every count alone
        xfer(1'b1, fcc_pkg::IDX_CHK_ENABLE, 32'h0);
        mac.send(4'h8);
        mac.send(4'h0);
        xfer(1'b1, fcc_pkg::IDX_CHK_ENABLE, 32'h1);
        rdchk(fcc_pkg::IDX_RX_ERR_COUNT, 32'h3);
        rdchk(fcc_pkg::IDX_FRAME_LOW, 32'h8);
        rdchk(fcc_pkg::IDX_LEN_ERR, 32'h2);
        rdchk(fcc_pkg::IDX_ALGN_ERR, 32'h2);
        rdchk(fcc_pkg::IDX_SYMB_ERR, 32'h1);
    endtask

    task automatic t_lanes();
        // only sel[0]/sel[1] gate writes; adr[1:0] and dat[31:16] are ignored
        xfer_sel(1'b1, fcc_pkg::IDX_IRQ_ENABLE, 32'hffff0001, 4'he, 2'h3);
        rdchk(fcc_pkg::IDX_IRQ_ENABLE, 32'h0);
        xfer_sel(1'b1, fcc_pkg::IDX_IRQ_ENABLE, 32'hffff0001, 4'h1, 2'h2);
        rdchk(fcc_pkg::IDX_IRQ_ENABLE, 32'h1);
        xfer_sel(1'b1, fcc_pkg::IDX_SUBSYS_MASK, 32'hffff2400, 4'h2, 2'h1);
        rdchk(fcc_pkg::IDX_SUBSYS_MASK, 32'h2402);
        // symbol error seen only on the end-of-frame beat
        mac.send(5'h10);
        @(posedge clk_i);
        irqchk(1'b0);
        xfer_sel(1'b1, fcc_pkg::IDX_SUBSYS_MASK, 32'h00004000, 4'h2, 2'h0);
        irqchk(1'b1);
        xfer_sel(1'b1, fcc_pkg::IDX_SUBSYS_CLEAR, 32'h00004000, 4'h1, 2'h0);
        irqchk(1'b1);
        xfer_sel(1'b1, fcc_pkg::IDX_SUBSYS_CLEAR, 32'hffff4000, 4'h2, 2'h3);
        irqchk(1'b0);
        rdchk(fcc_pkg::IDX_RX_ERR_COUNT, 32'h1);
        xfer_sel(1'b0, fcc_pkg::IDX_SYMB_ERR, 32'hffffffff, 4'h0, 2'h3);
        chk("symbol count", rd, 32'h2);
        rdchk(fcc_pkg::IDX_FRAME_LOW, 32'h9);
    endtask

    task automatic t_rerst();
        mac.send(5'h04);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(fcc_pkg::IDX_RX_ERR_COUNT, 32'h0);
        rdchk(fcc_pkg::IDX_FRAME_LOW, 32'h0);
        rdchk(fcc_pkg::IDX_SUBSYS_MASK, 32'h2402);
        rdchk(fcc_pkg::IDX_SOURCE_SELECT, 32'h0);
        irqchk(1'b0);
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_count();
        t_irq();
        t_lanes();
        t_rerst();
        tally_and_finish();
    end
endmodule
